//--- rtl/fcdc_pkg.sv
package fcdc_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NCH = 4;
    localparam int NEXT = 2;
    localparam int NPERI = 4;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int CNT_W = 24;
    localparam int GAP_CYCLES = 16;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] OFS_SRC = 4'h0;
    localparam logic [3:0] OFS_DST = 4'h4;
    localparam logic [3:0] OFS_CNT = 4'h8;
    localparam logic [3:0] OFS_CTL = 4'hc;
    localparam logic [AW-1:0] OFS_OP = 8'h40;
    localparam int CH_LSB = 4;
    localparam int COMMON_BIT = 6;
    localparam int TOP_BIT = 7;

    // ----------------------------------------
    // channel_control fields
    // ----------------------------------------
    localparam int B_DE = 0;
    localparam int B_TE = 1;
    localparam int B_IE = 2;
    localparam int B_SGL = 3;
    localparam int F_PSEL = 4;
    localparam int F_SIZE = 6;
    localparam int F_DET = 8;
    localparam int F_RSRC = 10;
    localparam int F_SM = 12;
    localparam int F_DM = 14;
    localparam int B_AL = 16;
    localparam int B_AM = 17;
    localparam int B_TL = 22;
    localparam int B_BURST = 24;
    localparam int B_INTM = 25;
    localparam int B_TOMEM = 26;
    localparam logic [DW-1:0] CTL_MASK_EXT = 32'h0743_ffff;
    localparam logic [DW-1:0] CTL_MASK_INT = 32'h0300_fff7;
    localparam logic [DW-1:0] CTL_RST = 32'h0000_0000;
    localparam int B_ME = 0;
    localparam int B_RR = 1;
    localparam logic [1:0] OP_RST = 2'h0;

    // ----------------------------------------
    // encodings
    // ----------------------------------------
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_16 = 2'h3;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    localparam logic [1:0] RS_AUTO = 2'h0;
    localparam logic [1:0] RS_EXT = 2'h1;
    localparam logic [1:0] RS_PERI = 2'h2;
    localparam logic [1:0] DT_LOW = 2'h0;
    localparam logic [1:0] DT_HIGH = 2'h1;
    localparam logic [1:0] DT_RISE = 2'h2;
    localparam logic [1:0] DT_FALL = 2'h3;
    localparam logic [1:0] LAST_BEAT = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
    localparam logic [DW-1:0] BEAT_BYTES = 32'h0000_0004;
    localparam logic [DW-1:0] ONE_BYTE = 32'h0000_0001;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} fcdc_state_e;

    // a 16-byte unit moves as four longword beats
    function automatic logic [DW-1:0] fcdc_step(input logic [1:0] sz);
        fcdc_step = (sz == SZ_16) ? BEAT_BYTES : (ONE_BYTE << sz);
    endfunction : fcdc_step
endpackage : fcdc_pkg

//--- rtl/fcdc_req_detect.sv
`timescale 1ns/100ps
module fcdc_req_detect (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic req_in,
    input wire logic [1:0] mode,
    input wire logic consume,
    output logic pending
);
    import fcdc_pkg::*;

    logic prev;
    logic armed;
    logic edge_flag;
    logic hit;

    // armed keeps a line that is already high at release from looking like an edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            prev <= 1'b0;
            armed <= 1'b0;
        end else begin
            prev <= req_in;
            armed <= 1'b1;
        end
    end

    always_comb begin
        hit = 1'b0;
        if (armed && mode == DT_RISE) begin
            hit = req_in & ~prev;
        end else if (armed && mode == DT_FALL) begin
            hit = ~req_in & prev;
        end
    end

    // an edge seen in the cycle it is consumed stays pending
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            edge_flag <= 1'b0;
        end else begin
            edge_flag <= hit | (edge_flag & ~consume);
        end
    end

    always_comb begin
        case (mode)
            DT_LOW: pending = ~req_in;
            DT_HIGH: pending = req_in;
            default: pending = edge_flag;
        endcase
    end

    a_edge_latch: assert property (@(posedge clk_sys) disable iff (!resetn) hit |=> pending)
        else $error("detected edge not held pending");
endmodule : fcdc_req_detect

//--- rtl/fcdc_top.sv
`timescale 1ns/100ps
// How it works
// - four channels; only channels 0 and 1 own request, acknowledge, end pins
// - unit is byte, word, longword or sixteen bytes as four longwords
// - dual address reads then writes; single address does one cycle
// - request comes from pin, a peripheral port, or auto request
// - cycle steal, normal or intermittent, or burst, per channel
// - fixed priority with channel 0 first, or round robin
// - finished count raises the interrupt when enabled
// - pin request seen as low, high, rising or falling edge
// - acknowledge and end polarities are set independently
// - outside device drives request; we drive acknowledge and end
// - source address is read/write and shows next read address
// - single mode from device leaves source address untouched
// - destination address is read/write and shows next write address
// - single mode towards device leaves destination address untouched
// - count one means one transfer, zero means two to the 24
// - reading count shows transfers still to do
// - count top byte reads zero and takes no write
// - a sixteen byte unit counts once
// - addresses and count have no reset value
// - end polarity bit: 0 active low, 1 active high
// - acknowledge in read (0) or write (1) cycle; always in single mode
// - acknowledge polarity bit: 0 active low, 1 active high
module fcdc_top #(
    parameter int GAP = fcdc_pkg::GAP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [fcdc_pkg::AW-1:0] reg_addr,
    input wire logic [fcdc_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fcdc_pkg::DW-1:0] reg_rdata,
    input wire logic [fcdc_pkg::NEXT-1:0] transfer_request_in,
    output logic [fcdc_pkg::NEXT-1:0] request_acknowledge_out,
    output logic [fcdc_pkg::NEXT-1:0] transfer_end_out,
    input wire logic [fcdc_pkg::NPERI-1:0] periph_request,
    output logic [fcdc_pkg::NPERI-1:0] periph_served,
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_size,
    output logic [fcdc_pkg::DW-1:0] mem_addr,
    output logic [fcdc_pkg::DW-1:0] mem_wdata,
    input wire logic [fcdc_pkg::DW-1:0] mem_rdata,
    input wire logic mem_ack,
    output logic irq
);
    import fcdc_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [DW-1:0] src [NCH];
    logic [DW-1:0] dst [NCH];
    logic [CNT_W-1:0] cnt [NCH];
    logic [DW-1:0] ctl [NCH];
    logic [1:0] op;

    fcdc_state_e state;
    logic [1:0] cur;
    logic [1:0] last;
    logic [1:0] beat;
    logic [15:0] gap_cnt;
    logic [DW-1:0] data;

    logic map_ok;
    logic [1:0] ch_sel;
    logic [3:0] reg_sel;
    logic [NCH-1:0] ch_wr;
    logic [NCH-1:0] ext_req;
    logic [NEXT-1:0] ext_pend;
    logic [NCH-1:0] req;
    logic [NCH-1:0] elig;
    logic [NCH-1:0] consume;
    logic grant_ok;
    logic [1:0] grant;
    logic [1:0] idx;
    logic [DW-1:0] cctl;
    logic [DW-1:0] gctl;
    logic [1:0] csize;
    logic sgl;
    logic [DW-1:0] step;
    logic rd_done;
    logic wr_done;
    logic beat_end;
    logic unit_end;
    logic last_unit;
    fcdc_state_e first_cur;
    fcdc_state_e first_grant;
    logic [DW-1:0] next_src;
    logic [DW-1:0] next_dst;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    assign map_ok = !reg_addr[TOP_BIT] && !reg_addr[COMMON_BIT];
    assign ch_sel = reg_addr[CH_LSB +: 2];
    assign reg_sel = reg_addr[3:0];

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_wr[i] = reg_wr && map_ok && (ch_sel == 2'(i));
        end
    end

    // ----------------------------------------
    // request sources
    // ----------------------------------------
    // pins on two channels
    genvar g;
    generate
        for (g = 0; g < NEXT; g++) begin : gen_det
            fcdc_req_detect u_det (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .req_in(transfer_request_in[g]),
                .mode(ctl[g][F_DET +: 2]),
                .consume(consume[g]),
                .pending(ext_pend[g])
            );
        end
    endgenerate

    assign ext_req = NCH'(ext_pend);

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            case (ctl[i][F_RSRC +: 2])
                RS_AUTO: req[i] = 1'b1;
                RS_EXT: req[i] = ext_req[i];
                RS_PERI: req[i] = periph_request[ctl[i][F_PSEL +: 2]];
                default: req[i] = 1'b0;
            endcase
            elig[i] = op[B_ME] & ctl[i][B_DE] & ~ctl[i][B_TE] & req[i];
            consume[i] = unit_end && (cur == 2'(i));
            periph_served[i] = 1'b0;
        end
        for (int i = 0; i < NCH; i++) begin
            if (consume[i] && ctl[i][F_RSRC +: 2] == RS_PERI) begin
                periph_served[ctl[i][F_PSEL +: 2]] = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    // fixed or round robin; descending loop lets the lowest slot win
    always_comb begin
        grant_ok = 1'b0;
        grant = '0;
        idx = '0;
        for (int k = NCH - 1; k >= 0; k--) begin
            idx = op[B_RR] ? 2'(last + 2'(k) + 2'(1)) : 2'(k);
            if (elig[idx]) begin
                grant_ok = 1'b1;
                grant = idx;
            end
        end
    end

    // ----------------------------------------
    // current transfer decode
    // ----------------------------------------
    assign cctl = ctl[cur];
    assign gctl = ctl[grant];
    assign csize = cctl[F_SIZE +: 2];
    assign sgl = cctl[B_SGL];
    assign step = fcdc_step(csize);
    assign rd_done = (state == ST_READ) && mem_ack;
    assign wr_done = (state == ST_WRITE) && mem_ack;
    // single mode ends a beat on either cycle
    assign beat_end = sgl ? (rd_done || wr_done) : wr_done;
    // four beats make one counted unit
    assign unit_end = beat_end && (csize != SZ_16 || beat == LAST_BEAT);
    assign last_unit = (cnt[cur] == CNT_ONE);
    assign first_cur = (sgl && cctl[B_TOMEM]) ? ST_WRITE : ST_READ;
    assign first_grant = (gctl[B_SGL] && gctl[B_TOMEM]) ? ST_WRITE : ST_READ;

    always_comb begin
        case (cctl[F_SM +: 2])
            AM_INC: next_src = src[cur] + step;
            AM_DEC: next_src = src[cur] - step;
            default: next_src = src[cur];
        endcase
        case (cctl[F_DM +: 2])
            AM_INC: next_dst = dst[cur] + step;
            AM_DEC: next_dst = dst[cur] - step;
            default: next_dst = dst[cur];
        endcase
    end

    // ----------------------------------------
    // transfer engine
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= ST_IDLE;
            cur <= '0;
            last <= '0;
            beat <= '0;
            gap_cnt <= '0;
            data <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (grant_ok) begin
                        cur <= grant;
                        last <= grant;
                        beat <= '0;
                        state <= first_grant;
                    end
                end
                ST_READ: begin
                    if (mem_ack) begin
                        data <= mem_rdata;
                        // dual mode follows the read with a write
                        if (!sgl) begin
                            state <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                end
                ST_GAP: begin
                    if (gap_cnt == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        gap_cnt <= gap_cnt - 16'(1);
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (beat_end && !unit_end) begin
                beat <= beat + 2'(1);
                state <= first_cur;
            end else if (unit_end) begin
                beat <= '0;
                if (last_unit) begin
                    state <= ST_IDLE;
                // burst keeps the bus, intermittent leaves a gap
                end else if (cctl[B_BURST] && elig[cur]) begin
                    state <= first_cur;
                end else if (cctl[B_INTM] && !cctl[B_BURST]) begin
                    state <= ST_GAP;
                    gap_cnt <= 16'(GAP - 1);
                end else begin
                    state <= ST_IDLE;
                end
            end
        end
    end

    // ----------------------------------------
    // address and count registers
    // ----------------------------------------
    // left without reset, software loads them before enabling
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NCH; i++) begin
            if (ch_wr[i] && reg_sel == OFS_SRC) begin
                src[i] <= reg_wdata;
            end
            if (ch_wr[i] && reg_sel == OFS_DST) begin
                dst[i] <= reg_wdata;
            end
            if (ch_wr[i] && reg_sel == OFS_CNT) begin
                cnt[i] <= reg_wdata[CNT_W-1:0];
            end
        end
        // source moves on each read; no read in single from device
        if (rd_done) begin
            src[cur] <= next_src;
        end
        // destination moves on each write; no write towards device
        if (wr_done) begin
            dst[cur] <= next_dst;
        end
        // zero wraps to all ones, so zero gives the full range
        if (unit_end) begin
            cnt[cur] <= cnt[cur] - CNT_ONE;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++) begin
                ctl[i] <= CTL_RST;
            end
            op <= OP_RST;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_wr[i] && reg_sel == OFS_CTL) begin
                    ctl[i] <= reg_wdata & ((i < NEXT) ? CTL_MASK_EXT : CTL_MASK_INT);
                    ctl[i][B_TE] <= ctl[i][B_TE] & reg_wdata[B_TE];
                end
                // end flag, set beats a clear in the same cycle
                if (unit_end && last_unit && cur == 2'(i)) begin
                    ctl[i][B_TE] <= 1'b1;
                end
            end
            if (reg_wr && reg_addr == OFS_OP) begin
                op <= reg_wdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd && reg_addr == OFS_OP) begin
            reg_rdata <= DW'(op);
        end else if (reg_rd && map_ok) begin
            case (reg_sel)
                OFS_SRC: reg_rdata <= src[ch_sel];
                OFS_DST: reg_rdata <= dst[ch_sel];
                // live remaining count; top byte zero
                OFS_CNT: reg_rdata <= DW'(cnt[ch_sel]);
                OFS_CTL: reg_rdata <= ctl[ch_sel];
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------
    // bus and pins
    // ----------------------------------------
    assign mem_req = (state == ST_READ) || (state == ST_WRITE);
    assign mem_we = (state == ST_WRITE);
    // sixteen byte units go out as longword beats
    assign mem_size = (csize == SZ_16) ? SZ_LONG : csize;
    assign mem_wdata = data;
    assign mem_addr = (state == ST_READ) ? src[cur] : (state == ST_WRITE) ? dst[cur] : '0;

    // end flag gated by its enable
    always_comb begin
        irq = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            irq = irq | (ctl[i][B_TE] & ctl[i][B_IE]);
        end
    end

    logic [NEXT-1:0] ack_act;
    logic [NEXT-1:0] end_act;
    // pins driven towards the outside device
    always_comb begin
        for (int i = 0; i < NEXT; i++) begin
            // cycle choice in dual mode, always in single mode
            ack_act[i] = mem_req && cur == 2'(i) && (ctl[i][B_SGL]
                || (ctl[i][F_RSRC +: 2] == RS_EXT && (mem_we == ctl[i][B_AM])));
            // end pin through the final unit
            end_act[i] = mem_req && cur == 2'(i) && last_unit;
            request_acknowledge_out[i] = ~(ack_act[i] ^ ctl[i][B_AL]);
            transfer_end_out[i] = ~(end_act[i] ^ ctl[i][B_TL]);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    logic [CNT_W-1:0] cnt_cur;
    logic [DW-1:0] src_cur;
    assign cnt_cur = cnt[cur];
    assign src_cur = src[cur];

    sequence s_dual_read;
        rd_done && !sgl;
    endsequence
    sequence s_final_unit;
        unit_end && last_unit;
    endsequence
    sequence s_mid_beat;
        beat_end && csize == SZ_16 && beat != LAST_BEAT;
    endsequence

    a_read_then_write: assert property (s_dual_read |=> state == ST_WRITE)
        else $error("dual read not followed by write");
    a_final_stops: assert property (s_final_unit |=> state == ST_IDLE && ctl[$past(cur)][B_TE])
        else $error("final unit did not stop channel");
    a_count_steps: assert property (unit_end && !last_unit |=> cnt_cur == $past(cnt_cur) - CNT_ONE)
        else $error("count did not drop by one");
    a_sixteen_once: assert property (s_mid_beat |=> cnt_cur == $past(cnt_cur) && mem_req)
        else $error("mid beat changed count");
    a_src_advance: assert property (rd_done && cctl[F_SM +: 2] == AM_INC
        |=> src_cur == $past(src_cur) + $past(step))
        else $error("source address not advanced");
    a_count_top_zero: assert property (reg_rd && map_ok && reg_sel == OFS_CNT
        |=> reg_rdata[DW-1:CNT_W] == '0)
        else $error("count top byte not zero");
    a_fixed_first: assert property (state == ST_IDLE && !op[B_RR] && elig[0] |=> cur == '0)
        else $error("channel 0 lost fixed priority");
    a_ack_level: assert property (ack_act[0] |-> request_acknowledge_out[0] == ctl[0][B_AL])
        else $error("acknowledge level wrong");
    a_end_level: assert property (end_act[1] |-> transfer_end_out[1] == ctl[1][B_TL])
        else $error("end level wrong");
    a_irq_raise: assert property (s_final_unit ##1 ctl[cur][B_IE] |-> irq)
        else $error("no interrupt at count end");
endmodule : fcdc_top

//--- verif/fcdc_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// memory side of the transfer bus
// ----------------------------------------
module fcdc_mem_model #(
    parameter logic [31:0] PAT = 32'h0000_0000
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] lat,
    output logic [31:0] mem_rdata,
    output logic mem_ack,
    output logic [31:0] last_addr,
    output logic [31:0] last_data,
    output int nwr
);
    logic [3:0] wcnt;
    logic go;

    assign go = resetn && mem_req && !mem_ack && (wcnt >= lat);

    // one ack per beat after lat wait cycles
    always_ff @(posedge clk_sys) begin
        if (!resetn || !mem_req || mem_ack) begin
            wcnt <= 4'h0;
        end else begin
            wcnt <= wcnt + 4'h1;
        end
        mem_ack <= go;
    end

    // data line toggles when not answering so a stale value never passes
    always_ff @(posedge clk_sys) begin
        mem_rdata <= (go && !mem_we) ? (mem_addr ^ PAT) : ~mem_rdata;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            nwr <= 0;
        end else if (mem_req && mem_ack && mem_we) begin
            last_addr <= mem_addr;
            last_data <= mem_wdata;
            nwr <= nwr + 1;
        end
    end
endmodule : fcdc_mem_model

//--- verif/four_channel_dma_controller_bench.sv
`timescale 1ns/100ps
module four_channel_dma_controller_bench;
    import fcdc_pkg::*;
    localparam logic [31:0] PAT = 32'ha5a5_0000;
    localparam logic [DW-1:0] TE = 32'h1 << B_TE;
    localparam logic [DW-1:0] C_BASE = (32'h1 << B_DE) | (32'h1 << B_IE) | (32'(AM_INC) << F_DM);
    localparam logic [DW-1:0] C_DUAL = C_BASE | (32'(AM_INC) << F_SM);
    localparam logic [DW-1:0] C_LONG = C_DUAL | (32'(SZ_LONG) << F_SIZE);
    localparam logic [DW-1:0] C_16 = C_DUAL | (32'(SZ_16) << F_SIZE)
        | (32'(RS_PERI) << F_RSRC) | (32'h2 << F_PSEL);
    localparam logic [DW-1:0] C_EDGE = C_BASE | (32'(AM_DEC) << F_SM) | (32'(DT_RISE) << F_DET)
        | (32'(RS_EXT) << F_RSRC) | (32'h1 << B_AM);
    localparam logic [DW-1:0] C_SGL = C_BASE | (32'(SZ_LONG) << F_SIZE) | (32'h1 << B_SGL)
        | (32'(DT_HIGH) << F_DET) | (32'(RS_EXT) << F_RSRC) | (32'h1 << B_AL)
        | (32'h1 << B_TL) | (32'h1 << B_TOMEM);
    logic clk_sys, resetn, reg_wr, reg_rd, mem_req, mem_we, mem_ack, irq;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, last_addr, last_data;
    logic [1:0] transfer_request_in, request_acknowledge_out, transfer_end_out, mem_size;
    logic [3:0] lat;
    logic [NPERI-1:0] periph_request, periph_served;
    int nwr, errors, samples_checked, nsrv;

    fcdc_top #(.GAP(2)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transfer_request_in(transfer_request_in),
        .request_acknowledge_out(request_acknowledge_out),
        .transfer_end_out(transfer_end_out), .periph_request(periph_request),
        .periph_served(periph_served),
        .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
    fcdc_mem_model #(.PAT(PAT)) u_mem (.clk_sys(clk_sys), .resetn(resetn),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .last_addr(last_addr),
        .last_data(last_data), .nwr(nwr));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // one pulse per finished unit of the peripheral on slot 2
    always @(posedge clk_sys) begin
        if (periph_served[2] === 1'b1) begin
            nsrv <= nsrv + 1;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask : rchk

    task automatic setup(input logic [AW-1:0] b, input logic [DW-1:0] s, d, n);
        wr(b, s);
        wr(b + 8'h4, d);
        wr(b + 8'h8, n);
    endtask : setup

    // size is checked on every bus cycle while waiting; pins too when ext picks channel 0 or 1
    task automatic wait_irq(input logic [1:0] ext, input logic [1:0] sz);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            if (mem_req === 1'b1) begin
                chk(32'(mem_size), 32'(sz));
            end
            if (ext == 2'h1 && mem_req === 1'b1) begin
                chk(32'(request_acknowledge_out[0]), 32'h1);
                chk(32'(transfer_end_out[0]), 32'h1);
            end
            if (ext == 2'h2 && mem_req === 1'b1) begin
                chk(32'(request_acknowledge_out[1]), 32'(!mem_we));
                chk(32'(transfer_end_out[1]), 32'h0);
            end
            n++;
        end
        if (n == 300) begin
            errors++;
            end_sim();
        end
    endtask : wait_irq

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {resetn, reg_wr, reg_rd, transfer_request_in, lat, periph_request} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        chk(32'({irq, request_acknowledge_out, transfer_end_out}), 32'hf);
        wr(OFS_OP, 32'h1);
        setup(8'h00, 32'h1000, 32'h2000, 32'hff00_0002);
        rchk(8'h08, 32'h2);
        rchk(8'h00, 32'h1000);
        rchk(8'h04, 32'h2000);
        wr(8'h44, 32'hffff_ffff);
        rchk(8'h44, 32'h0);
        wr(8'h0c, C_LONG);
        wait_irq(2'h0, SZ_LONG);
        rchk(8'h08, 32'h0);
        rchk(8'h00, 32'h1008);
        rchk(8'h04, 32'h2008);
        rchk(8'h0c, C_LONG | TE);
        chk(last_addr, 32'h2004);
        chk(last_data, 32'h1004 ^ PAT);
        chk(32'(nwr), 32'h2);
        wr(8'h0c, 32'h0);
        @(negedge clk_sys);
        chk(32'(irq), 32'h0);
        lat <= 4'h3;
        setup(8'h10, 32'h3000, 32'h4000, 32'h1);
        periph_request <= 4'h4;
        wr(8'h1c, C_16);
        wait_irq(2'h0, SZ_LONG);
        rchk(8'h18, 32'h0);
        rchk(8'h10, 32'h3010);
        rchk(8'h14, 32'h4010);
        chk(32'(nwr), 32'h6);
        chk(32'(nsrv), 32'h1);
        wr(8'h1c, 32'h0);
        lat <= 4'h0;
        setup(8'h00, 32'h5000, 32'h6000, 32'h1);
        wr(8'h0c, C_SGL);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'({mem_req, request_acknowledge_out[0], transfer_end_out[0]}), 32'h0);
        @(posedge clk_sys);
        transfer_request_in <= 2'b01;
        wait_irq(2'h1, SZ_LONG);
        @(posedge clk_sys);
        transfer_request_in <= 2'b00;
        rchk(8'h00, 32'h5000);
        rchk(8'h04, 32'h6004);
        wr(8'h0c, 32'h0);
        transfer_request_in <= 2'b10;
        setup(8'h10, 32'h7003, 32'h8000, 32'h1);
        wr(8'h1c, C_EDGE);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(mem_req), 32'h0);
        @(posedge clk_sys);
        transfer_request_in <= 2'b00;
        @(posedge clk_sys);
        transfer_request_in <= 2'b10;
        wait_irq(2'h2, SZ_BYTE);
        chk(last_data, 32'h7003 ^ PAT);
        rchk(8'h10, 32'h7002);
        rchk(8'h14, 32'h8001);
        end_sim();
    end
endmodule : four_channel_dma_controller_bench
